// File: verilog/dbcp_top.v
// Two-channel buck cycle control with fault sequencing and voltage codes.
`timescale 1ns/1ps
`include "dbcp_defs.vh"
// Contract
// - No serial link: external divider only.
// - Codes at register 0x00 and 0x01.
// - Apply strobe switches to internal divider.
// - Channel two starts half period later.
// - Overshoot holds high side off.
// - Full duty allowed while boot healthy.
// - Boot undervoltage forces low side recharge.
// - Peak trip ends high side pulse.
// - Source limit skips next high pulse.
// - Resume when source limit clear at start.
// - Sink limit turns both off (the code forces only the low side off).
// - Overload 512 cycles: 16384 cycle hiccup.
// - Sharing mode ignores channel two inputs.
// - Sharing mode disables pulse skipping.
// - Overtemperature stops, hiccup after clearing.
// - Pulse skip suspends below light load.
module dbcp_top (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       serial_active,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_q,
    input  wire [7:0] period_cycles,
    input  wire       share_mode,
    input  wire       overload,
    input  wire       over_temp,
    input  wire       overshoot_guard,
    input  wire       second_overshoot_guard,
    input  wire       boot_uv1,
    input  wire       boot_uv2,
    input  wire       peak_trip1,
    input  wire       peak_trip2,
    input  wire       ls_source_trip1,
    input  wire       ls_source_trip2,
    input  wire       ls_sink_trip1,
    input  wire       ls_sink_trip2,
    input  wire       light_load1,
    input  wire       light_load2,
    output wire       hs_on1,
    output wire       ls_on1,
    output wire       hs_on2,
    output wire       ls_on2,
    output reg        use_internal1_q,
    output reg        use_internal2_q,
    output reg  [7:0] voltage_code1_q,
    output reg  [7:0] voltage_code2_q,
    output reg        softstart_restart_q
);
    reg [7:0]  code1_q;
    reg [7:0]  code2_q;
    reg        pskip_q;
    reg [7:0]  phase_q;
    reg [9:0]  ovl_cnt_q;
    reg [14:0] hic_cnt_q;
    reg [1:0]  state_q;
    reg [1:0]  state_d;
    wire       start1;
    wire       start2;
    wire       run_en;
    wire       skip_en;
    wire [7:0] half_period;
    wire       ch2_ovp;
    wire       ch2_buv;
    wire       ch2_peak;
    wire       ch2_src;
    wire       ch2_sink;
    wire       ch2_light;
    wire       hs2_raw;
    wire       ls2_raw;

    // Decodes a register address match.
    function addr_is;
        input [7:0] a;
        input [7:0] b;
        begin
            addr_is = (a == b);
        end
    endfunction

    // Register writes; the apply strobe latches the codes into the divider path.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            code1_q         <= `DBCP_CODE_RESET;
            code2_q         <= `DBCP_CODE_RESET;
            pskip_q         <= 1'b0;
            use_internal1_q <= 1'b0;
            use_internal2_q <= 1'b0;
            voltage_code1_q <= `DBCP_CODE_RESET;
            voltage_code2_q <= `DBCP_CODE_RESET;
        end else if (!serial_active) begin
            use_internal1_q <= 1'b0;
            use_internal2_q <= 1'b0;
        end else if (reg_wr) begin
            if (addr_is(reg_addr, `DBCP_REG_CH1_CODE)) begin
                code1_q <= reg_wdata;
            end
            if (addr_is(reg_addr, `DBCP_REG_CH2_CODE)) begin
                code2_q <= reg_wdata;
            end
            if (addr_is(reg_addr, `DBCP_REG_CMD)) begin
                pskip_q <= reg_wdata[`DBCP_CMD_PSKIP_BIT];
                if (reg_wdata[`DBCP_CMD_APPLY_BIT]) begin
                    use_internal1_q <= 1'b1;
                    use_internal2_q <= 1'b1;
                    voltage_code1_q <= code1_q;
                    voltage_code2_q <= code2_q;
                end
            end
        end
    end

    // Register read-back, unmapped addresses read zero.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (addr_is(reg_addr, `DBCP_REG_CH1_CODE)) begin
                reg_rdata_q <= code1_q;
            end else if (addr_is(reg_addr, `DBCP_REG_CH2_CODE)) begin
                reg_rdata_q <= code2_q;
            end else if (addr_is(reg_addr, `DBCP_REG_CMD)) begin
                reg_rdata_q <= {6'h00, pskip_q, 1'b0};
            end else if (addr_is(reg_addr, `DBCP_REG_STATUS)) begin
                reg_rdata_q <= {4'h0, use_internal2_q, use_internal1_q, state_q};
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end

    // Switching period counter; channel two starts at the half point.
    assign half_period = {1'b0, period_cycles[7:1]};
    assign start1      = (phase_q == 8'h00);
    assign start2      = (phase_q == half_period);

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_q <= 8'h00;
        end else if (phase_q + 8'h01 >= period_cycles) begin
            phase_q <= 8'h00;
        end else begin
            phase_q <= phase_q + 8'h01;
        end
    end

    // Fault sequencer next state.
    always @* begin
        state_d = state_q;
        case (state_q)
            `DBCP_ST_RUN: begin
                if (over_temp) begin
                    state_d = `DBCP_ST_HOT;
                end else if (start1 && overload && ovl_cnt_q >= `DBCP_OVL_LIMIT) begin
                    state_d = `DBCP_ST_HICCUP;
                end
            end
            `DBCP_ST_HICCUP: begin
                if (over_temp) begin
                    state_d = `DBCP_ST_HOT;
                end else if (start1 && hic_cnt_q == `DBCP_HICCUP_CYCLES - 15'h0001) begin
                    state_d = `DBCP_ST_RUN;
                end
            end
            `DBCP_ST_HOT: begin
                if (!over_temp) begin
                    state_d = `DBCP_ST_HICCUP;
                end
            end
            default: begin
                state_d = `DBCP_ST_RUN;
            end
        endcase
    end

    // Overload and hiccup cycle counters, counted per switching period.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q             <= `DBCP_ST_RUN;
            ovl_cnt_q           <= 10'h000;
            hic_cnt_q           <= 15'h0000;
            softstart_restart_q <= 1'b0;
        end else begin
            state_q             <= state_d;
            softstart_restart_q <= (state_q != `DBCP_ST_RUN) && (state_d == `DBCP_ST_RUN);
            if (!overload || state_q != `DBCP_ST_RUN) begin
                ovl_cnt_q <= 10'h000;
            end else if (start1 && ovl_cnt_q < `DBCP_OVL_LIMIT) begin
                ovl_cnt_q <= ovl_cnt_q + 10'h001;
            end
            if (state_q != `DBCP_ST_HICCUP) begin
                hic_cnt_q <= 15'h0000;
            end else if (start1) begin
                hic_cnt_q <= hic_cnt_q + 15'h0001;
            end
        end
    end

    assign run_en  = (state_q == `DBCP_ST_RUN);
    assign skip_en = pskip_q && !share_mode;

    // In sharing mode channel two follows channel one's comparators.
    assign ch2_ovp   = share_mode ? overshoot_guard : second_overshoot_guard;
    assign ch2_buv   = share_mode ? boot_uv1 : boot_uv2;
    assign ch2_peak  = share_mode ? peak_trip1 : peak_trip2;
    assign ch2_src   = share_mode ? ls_source_trip1 : ls_source_trip2;
    assign ch2_sink  = share_mode ? ls_sink_trip1 : ls_sink_trip2;
    assign ch2_light = share_mode ? 1'b0 : light_load2;

    dbcp_channel u_ch1 (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .cycle_start     (start1),
        .run_en          (run_en),
        .overshoot_guard (overshoot_guard),
        .boot_uv         (boot_uv1),
        .peak_trip       (peak_trip1),
        .ls_source_trip  (ls_source_trip1),
        .ls_sink_trip    (ls_sink_trip1),
        .skip_light      (skip_en && light_load1),
        .hs_on_q         (hs_on1),
        .ls_on_q         (ls_on1)
    );

    dbcp_channel u_ch2 (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .cycle_start     (start2),
        .run_en          (run_en),
        .overshoot_guard (ch2_ovp),
        .boot_uv         (ch2_buv),
        .peak_trip       (ch2_peak),
        .ls_source_trip  (ch2_src),
        .ls_sink_trip    (ch2_sink),
        .skip_light      (skip_en && ch2_light),
        .hs_on_q         (hs2_raw),
        .ls_on_q         (ls2_raw)
    );

    assign hs_on2 = hs2_raw;
    assign ls_on2 = ls2_raw;
endmodule

// File: verilog/dbcp_defs.vh
// Constants for the dual buck cycle protection block.
`ifndef DBCP_DEFS_VH
`define DBCP_DEFS_VH
`define DBCP_REG_CH1_CODE   8'h00
`define DBCP_REG_CH2_CODE   8'h01
`define DBCP_REG_CMD        8'h02
`define DBCP_REG_STATUS     8'h03
`define DBCP_CMD_APPLY_BIT  0
`define DBCP_CMD_PSKIP_BIT  1
`define DBCP_CODE_RESET     8'h00
`define DBCP_PERIOD_W       8
`define DBCP_OVL_LIMIT      10'h200
`define DBCP_HICCUP_CYCLES  15'h4000
`define DBCP_ST_RUN         2'h0
`define DBCP_ST_HICCUP      2'h1
`define DBCP_ST_HOT         2'h2
`endif

// File: verilog/dbcp_channel.v
// One channel's cycle-by-cycle switch control.
`timescale 1ns/1ps
module dbcp_channel (
    input  wire clk_sys,
    input  wire rst_n,
    input  wire cycle_start,
    input  wire run_en,
    input  wire overshoot_guard,
    input  wire boot_uv,
    input  wire peak_trip,
    input  wire ls_source_trip,
    input  wire ls_sink_trip,
    input  wire skip_light,
    output reg  hs_on_q,
    output reg  ls_on_q
);
    reg hs_d;
    reg ls_d;
    reg sink_off_q;
    reg ovp_q;

    // Next switch state from cycle start and the comparators.
    always @* begin
        hs_d = hs_on_q;
        ls_d = ls_on_q;
        if (!run_en) begin
            hs_d = 1'b0;
            ls_d = 1'b0;
        end else if (cycle_start) begin
            if (ls_source_trip) begin
                hs_d = 1'b0;
                ls_d = 1'b1;
            end else if (ovp_q || overshoot_guard || skip_light) begin
                hs_d = 1'b0;
                ls_d = 1'b1;
            end else if (boot_uv || peak_trip) begin
                hs_d = 1'b0;
                ls_d = 1'b1;
            end else begin
                hs_d = 1'b1;
                ls_d = 1'b0;
            end
        end else begin
            if (hs_on_q && (peak_trip || boot_uv || overshoot_guard)) begin
                hs_d = 1'b0;
                ls_d = 1'b1;
            end
            if (ls_d && (ls_sink_trip || sink_off_q)) begin
                ls_d = 1'b0;
            end
        end
    end

    // Switch registers and per-cycle latches.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            hs_on_q     <= 1'b0;
            ls_on_q     <= 1'b0;
            sink_off_q  <= 1'b0;
            ovp_q       <= 1'b0;
        end else begin
            hs_on_q     <= hs_d;
            ls_on_q     <= ls_d;
            // Sink trip holds the low side off until the next cycle start.
            sink_off_q  <= cycle_start ? 1'b0 : (sink_off_q | ls_sink_trip);
            // Overshoot seen mid-cycle keeps high side off through the whole next cycle.
            ovp_q       <= cycle_start ? overshoot_guard : (ovp_q | overshoot_guard);
        end
    end
endmodule

// File: dv/dbcp_stage_model.sv
// Power stage model: the peak comparator trips after a set high-side on time.
`timescale 1ns/1ps
module dbcp_stage_model (
    input  wire       clk_sys,
    input  wire       hs_on,
    input  wire [7:0] on_len,
    output wire       peak_trip
);
    reg [7:0] ramp_q = 8'h00;
    // Current ramps while the high side conducts; a zero length never trips.
    always @(posedge clk_sys) begin
        ramp_q <= hs_on ? ramp_q + 8'h01 : 8'h00;
    end
    // The comparator drops as soon as the high side is off.
    assign peak_trip = hs_on && on_len != 8'h00 && ramp_q >= on_len;
endmodule

// File: dv/dbcp_properties.sv
// Concurrent checks on the ports of the dual buck cycle control.
`timescale 1ns/1ps
module dbcp_properties (
    input wire       clk_sys, rst_n, serial_active, reg_wr, reg_rd,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata_q,
    input wire       over_temp, overshoot_guard, boot_uv1, peak_trip1, ls_sink_trip1,
    input wire       hs_on1, ls_on1, hs_on2, ls_on2,
    input wire       use_internal1_q, use_internal2_q, softstart_restart_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A code write followed at once by a read of the same place.
    sequence code_wr; serial_active && reg_wr && reg_addr == 8'h00; endsequence
    sequence code_rd; reg_rd && reg_addr == 8'h00; endsequence
    ext_only_a: assert property (!serial_active |=> !use_internal1_q && !use_internal2_q)
        else $error("internal divider used without link");
    code_readback_a: assert property (code_wr ##1 code_rd |=> reg_rdata_q == $past(reg_wdata, 2))
        else $error("code readback differs");
    apply_internal_a: assert property (serial_active && reg_wr && reg_addr == 8'h02
        && reg_wdata[0] |=> use_internal1_q && use_internal2_q) else $error("apply ignored");
    overshoot_off_a: assert property (overshoot_guard |=> !hs_on1)
        else $error("high side on in overshoot");
    boot_off_a: assert property (boot_uv1 |=> !hs_on1)
        else $error("high side on with low gate supply");
    peak_off_a: assert property (peak_trip1 |=> !hs_on1)
        else $error("high side on after peak trip");
    sink_off_a: assert property (ls_sink_trip1 && ls_on1 |=> !ls_on1)
        else $error("switch on after sink trip");
    hot_stop_a: assert property (over_temp [*2] |=> !hs_on1 && !ls_on1 && !hs_on2 && !ls_on2)
        else $error("switching while hot");
    restart_pulse_a: assert property ($rose(softstart_restart_q) |=> !softstart_restart_q)
        else $error("restart pulse too long");
endmodule
bind dbcp_top dbcp_properties chk_u (.clk_sys, .rst_n, .serial_active, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata_q, .over_temp, .overshoot_guard, .boot_uv1, .peak_trip1,
    .ls_sink_trip1, .hs_on1, .ls_on1, .hs_on2, .ls_on2, .use_internal1_q, .use_internal2_q,
    .softstart_restart_q);

// File: dv/testbench.sv
// Self-checking bench for the dual buck cycle control.
`timescale 1ns/1ps
module testbench;
    reg        clk_sys = 1'b0, rst_n = 1'b0, serial_active = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, period_cycles = 8'h10, on_len = 8'h04;
    reg        share_mode = 1'b0, overload = 1'b0, over_temp = 1'b0, overshoot_guard = 1'b0;
    reg        second_overshoot_guard = 1'b0, boot_uv1 = 1'b0, boot_uv2 = 1'b0;
    reg        ls_source_trip1 = 1'b0, ls_source_trip2 = 1'b0, ls_sink_trip1 = 1'b0;
    reg        ls_sink_trip2 = 1'b0, light_load1 = 1'b0, light_load2 = 1'b0;
    wire       peak_trip1, peak_trip2, hs_on1, ls_on1, hs_on2, ls_on2;
    wire       use_internal1_q, use_internal2_q, softstart_restart_q;
    wire [7:0] reg_rdata_q, voltage_code1_q, voltage_code2_q;
    reg  [7:0] v;
    integer    mismatches = 0, num_checks = 0, n, t1;
    dbcp_top dut_u (.clk_sys, .rst_n, .serial_active, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata_q, .period_cycles, .share_mode, .overload, .over_temp, .overshoot_guard,
        .second_overshoot_guard, .boot_uv1, .boot_uv2, .peak_trip1, .peak_trip2,
        .ls_source_trip1, .ls_source_trip2, .ls_sink_trip1, .ls_sink_trip2, .light_load1,
        .light_load2, .hs_on1, .ls_on1, .hs_on2, .ls_on2, .use_internal1_q, .use_internal2_q,
        .voltage_code1_q, .voltage_code2_q, .softstart_restart_q);
    dbcp_stage_model s1_u (.clk_sys, .hs_on(hs_on1), .on_len, .peak_trip(peak_trip1));
    dbcp_stage_model s2_u (.clk_sys, .hs_on(hs_on2), .on_len, .peak_trip(peak_trip2));
    // The clock toggles every half period of 2 ns.
    always #2 clk_sys = ~clk_sys;
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Inputs always change 1 ns after a rising edge.
    task tick(input integer k); begin repeat (k) @(posedge clk_sys); #1; end endtask
    task wr(input [7:0] a, input [7:0] d);
        begin reg_addr = a; reg_wdata = d; reg_wr = 1'b1; tick(1); reg_wr = 1'b0; end
    endtask
    task rd(input [7:0] a);
        begin reg_addr = a; reg_rd = 1'b1; tick(1); reg_rd = 1'b0; tick(1); v = reg_rdata_q; end
    endtask
    // Counts cycles with the chosen high side on.
    task cnt(input w, input integer k);
        begin n = 0; repeat (k) begin tick(1); n = n + (w ? hs_on2 : hs_on1); end end
    endtask
    // Waits for the chosen high side to go low and then high.
    task edge_of(input w);
        begin
            while ((w ? hs_on2 : hs_on1) !== 1'b0 && t1 < 200) begin tick(1); t1 = t1 + 1; end
            while ((w ? hs_on2 : hs_on1) !== 1'b1 && t1 < 200) begin tick(1); t1 = t1 + 1; end
        end
    endtask
    task wait_ss;
        begin t1 = 0; while (softstart_restart_q !== 1'b1 && t1 < 34000) begin tick(1); t1 = t1 + 1; end end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // A hang is cut short well past the expected run length.
    initial begin #380000; mismatches = mismatches + 1; results; end
    initial begin
        tick(16); rst_n = 1'b1;
        // The divider sets the startup level; codes are applied only later.
        wr(8'h00, 8'h5A); rd(8'h00); chk(v, 8'h00); chk(use_internal1_q, 1'b0);
        serial_active = 1'b1; wr(8'h00, 8'h5A); wr(8'h01, 8'hA5);
        rd(8'h00); chk(v, 8'h5A); rd(8'h01); chk(v, 8'hA5); rd(8'h7F); chk(v, 8'h00);
        wr(8'h02, 8'h01); tick(1); chk(voltage_code1_q, 8'h5A); chk(voltage_code2_q, 8'hA5);
        chk({use_internal1_q, use_internal2_q}, 8'h03);
        serial_active = 1'b0; tick(2); chk(use_internal1_q, 1'b0); serial_active = 1'b1;
        $display("test registers done");
        t1 = 0; edge_of(0); t1 = 0; edge_of(1); chk(t1, 8);
        t1 = 0; edge_of(0); t1 = 0; edge_of(0); chk(t1, 16);
        cnt(0, 16); chk(n > 0 && n < 16, 1'b1);
        on_len = 8'h00; tick(20); cnt(0, 48); chk(n, 48);
        boot_uv1 = 1'b1; tick(2); chk({hs_on1, ls_on1}, 8'h01); boot_uv1 = 1'b0;
        overshoot_guard = 1'b1; tick(2); cnt(0, 32); chk(n, 0);
        overshoot_guard = 1'b0; cnt(0, 40); chk(n > 0, 1'b1);
        ls_source_trip1 = 1'b1; tick(20); cnt(0, 32); chk(n, 0); chk(ls_on1, 1'b1);
        ls_source_trip1 = 1'b0; cnt(0, 40); chk(n > 0, 1'b1);
        on_len = 8'h04; t1 = 0; edge_of(0); tick(8); ls_sink_trip1 = 1'b1; tick(2);
        chk({hs_on1, ls_on1}, 8'h00); ls_sink_trip1 = 1'b0;
        $display("test switching done");
        share_mode = 1'b1; second_overshoot_guard = 1'b1; ls_source_trip2 = 1'b1;
        tick(20); cnt(1, 32); chk(n > 0, 1'b1);
        wr(8'h02, 8'h02); light_load1 = 1'b1; light_load2 = 1'b1;
        tick(20); cnt(0, 32); chk(n > 0, 1'b1);
        share_mode = 1'b0; tick(20); cnt(0, 32); chk(n, 0);
        light_load1 = 1'b0; cnt(0, 40); chk(n > 0, 1'b1);
        $display("test sharing done");
        rst_n = 1'b0; period_cycles = 8'h02; tick(2); rst_n = 1'b1;
        overload = 1'b1; tick(1000); overload = 1'b0; tick(4); overload = 1'b1; tick(1000);
        rd(8'h03); chk(v & 8'h03, 8'h00);
        tick(100); rd(8'h03); chk(v & 8'h03, 8'h01); cnt(0, 20); chk(n, 0);
        cnt(1, 20); chk(n, 0); wait_ss; chk(t1 >= 32000 && t1 < 34000, 1'b1);
        overload = 1'b0;
        over_temp = 1'b1; tick(3); rd(8'h03); chk(v & 8'h03, 8'h02);
        over_temp = 1'b0; tick(2); rd(8'h03); chk(v & 8'h03, 8'h01);
        wait_ss; chk(t1 >= 32000 && t1 < 34000, 1'b1);
        $display("test faults done");
        results;
    end
endmodule
